//--- common/ep_event_consts.vh
// register offsets, field positions and reset values for the endpoint event flag block
`ifndef EP_EVENT_CONSTS_VH
`define EP_EVENT_CONSTS_VH
// byte addresses (chosen, no offsets printed)
`define OFS_EVENT_FLAGS   4'h0
`define OFS_EP_DONE       4'h4
`define OFS_EP_MASK       4'h8
`define OFS_ZLEN_FLAGS    4'hC
// event register fields
`define BIT_SETUP_SEEN    0
`define BIT_STATUS_SEEN   1
`define BIT_STATUS_DONE   2
`define BIT_ZLEN_AGG      3
`define BIT_EP_AGG        6
`define EVENT_WIDTH       7
// reset values
`define RST_EVENT         7'h00
`define RST_EP            8'h00
// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

//--- rtl/sticky_flags.v
// per-bit sticky flag bank: set by hardware, cleared by write-one
`timescale 1ns/1ns
module sticky_flags #(
   parameter WIDTH = 8
) (
   // clock and reset
   input  wire             aclk,
   input  wire             aresetn,
   // set and clear
   input  wire [WIDTH-1:0] set_pulse,
   input  wire [WIDTH-1:0] clear_ones,
   // state
   output wire [WIDTH-1:0] flags
);
   genvar i;

   // set wins over a clear landing in the same cycle so no event is lost
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg bit_reg;
         always @(posedge aclk) begin
            if (!aresetn)
               bit_reg <= 1'b0;
            else if (set_pulse[i])
               bit_reg <= 1'b1;
            else if (clear_ones[i])
               bit_reg <= 1'b0;
         end
         // one flip-flop per bit keeps each flag with a single driver
         assign flags[i] = bit_reg;
      end
   endgenerate
endmodule // sticky_flags

//--- rtl/ctrl_stage_decode.v
// turns endpoint 0 control-transfer events into flag set pulses
`timescale 1ns/1ns
module ctrl_stage_decode (
   // events from the protocol engine
   input  wire setup_token,
   input  wire status_token,
   input  wire status_token_in,
   input  wire ctrl_read,
   input  wire status_zlp_ok,
   // set pulses
   output wire set_setup_seen,
   output wire set_status_seen,
   output wire set_status_done
);
   // setup token always marks a new control transfer
   assign set_setup_seen  = setup_token;
   // status packet in control read, or the IN token ending a control write data stage
   assign set_status_seen = status_token & (ctrl_read | status_token_in);
   // zero-length status packet handshaked either direction
   assign set_status_done = status_zlp_ok;
endmodule // ctrl_stage_decode

//--- rtl/ep_event_flags.v
// endpoint event flags, masks and axi4-lite register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ep_event_consts.vh"

// Operation
// - status done sets event bit two
// - done means status zero-length packet handshaked
// - status packet in control read sets bit1
// - status IN token after write sets bit1
// - setup token sets event bit zero
// - done flags bits seven-one for endpoints
// - mask one blocks done and zero-length lines
// - masked endpoint still sets done flag
// - masked endpoint still sets zero-length flag
// - mask bit zero only gates zero-length
// - write one aggregate clears all done
module ep_event_flags #(
   parameter NUM_EP = 8
) (
   // clock and reset
   input  wire              aclk,
   input  wire              aresetn,
   // axi4-lite write address
   input  wire [3:0]        s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   // axi4-lite read address
   input  wire [3:0]        s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   // axi4-lite read data
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // one-cycle events from the protocol engine
   input  wire              setup_token,
   input  wire              status_token,
   input  wire              status_token_in,
   input  wire              ctrl_read,
   input  wire              status_zlp_ok,
   input  wire [NUM_EP-1:0] ep_xfer_done,
   input  wire [NUM_EP-1:0] ep_zlen_rx,
   // event lines
   output reg               endpoint_event_line,
   output reg               zero_length_event_line,
   output reg               irq
);
   // ********************************************************
   // write channel
   // ********************************************************
   reg  [3:0]        wr_addr_reg;
   reg               aw_held_reg;
   reg  [31:0]       wr_data_reg;
   reg  [3:0]        wr_strb_reg;
   reg               w_held_reg;
   wire              wr_fire;
   wire              wr_lane0;
   wire [1:0]        wr_resp;

   // either channel may arrive first; both held until the response is out
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         wr_addr_reg   <= 4'h0;
         wr_data_reg   <= 32'h0000_0000;
         wr_strb_reg   <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_held_reg && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            aw_held_reg   <= 1'b1;
            wr_addr_reg   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg && !s_axi_wready && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
            w_held_reg   <= 1'b1;
            wr_data_reg  <= s_axi_wdata;
            wr_strb_reg  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
         end
      end
   end

   assign wr_fire  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign wr_lane0 = wr_fire & wr_strb_reg[0]; // all fields sit in byte lane 0

   // an unaligned write matches no register and is dropped, so say so in the response
   assign wr_resp  = (wr_addr_reg[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;

   // write response, one cycle after both halves are held
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_resp;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ********************************************************
   // flag banks
   // ********************************************************
   wire                  set_setup_seen;
   wire                  set_status_seen;
   wire                  set_status_done;
   wire [`EVENT_WIDTH-1:0] evt_flags;
   reg  [`EVENT_WIDTH-1:0] evt_set;
   wire [`EVENT_WIDTH-1:0] evt_clr;
   wire [NUM_EP-1:0]     ep_done;
   wire [NUM_EP-1:0]     ep_done_set;
   wire [NUM_EP-1:0]     ep_done_clr;
   wire [NUM_EP-1:0]     zlen;
   wire [NUM_EP-1:0]     zlen_clr;
   wire                  wr_evt;
   wire                  wr_done;
   wire                  wr_zlen;
   wire                  wr_mask;
   reg  [3:0]            wr_sel;
   wire                  agg_ep_clr;
   wire                  agg_zlen_clr;
   reg  [NUM_EP-1:0]     mask_reg;
   reg  [NUM_EP-1:0]     mask_next;

   ctrl_stage_decode u_ctrl (
      .setup_token     (setup_token),
      .status_token    (status_token),
      .status_token_in (status_token_in),
      .ctrl_read       (ctrl_read),
      .status_zlp_ok   (status_zlp_ok),
      .set_setup_seen  (set_setup_seen),
      .set_status_seen (set_status_seen),
      .set_status_done (set_status_done)
   );

   // one select per register; an unmapped or unaligned offset selects nothing
   always @* begin
      wr_sel = 4'h0;
      case (wr_addr_reg)
         `OFS_EVENT_FLAGS: wr_sel = 4'h1;
         `OFS_EP_DONE:     wr_sel = 4'h2;
         `OFS_EP_MASK:     wr_sel = 4'h4;
         `OFS_ZLEN_FLAGS:  wr_sel = 4'h8;
         default:          wr_sel = 4'h0;
      endcase
   end

   // a write lands only once both halves are held and byte lane 0 is enabled
   assign wr_evt  = wr_lane0 & wr_sel[0];
   assign wr_done = wr_lane0 & wr_sel[1];
   assign wr_mask = wr_lane0 & wr_sel[2];
   assign wr_zlen = wr_lane0 & wr_sel[3];

   // aggregate bits: writing one clears the whole per-endpoint bank
   assign agg_ep_clr   = wr_evt & wr_data_reg[`BIT_EP_AGG];
   assign agg_zlen_clr = wr_evt & wr_data_reg[`BIT_ZLEN_AGG];

   // each event lands on its own field; aggregates follow their banks whatever the mask
   always @* begin
      evt_set                   = {`EVENT_WIDTH{1'b0}};
      evt_set[`BIT_SETUP_SEEN]  = set_setup_seen;
      evt_set[`BIT_STATUS_SEEN] = set_status_seen;
      evt_set[`BIT_STATUS_DONE] = set_status_done;
      evt_set[`BIT_ZLEN_AGG]    = |ep_zlen_rx;
      evt_set[`BIT_EP_AGG]      = |ep_done_set;
   end

   // write-one-to-clear on every event field
   assign evt_clr = {`EVENT_WIDTH{wr_evt}} & wr_data_reg[`EVENT_WIDTH-1:0];

   // endpoint 0 has no done flag; bit 0 never sets
   assign ep_done_set = {ep_xfer_done[NUM_EP-1:1], 1'b0};
   assign ep_done_clr = ({NUM_EP{wr_done}} & wr_data_reg[NUM_EP-1:0])
                      | {NUM_EP{agg_ep_clr}};
   assign zlen_clr    = ({NUM_EP{wr_zlen}} & wr_data_reg[NUM_EP-1:0])
                      | {NUM_EP{agg_zlen_clr}};

   sticky_flags #(.WIDTH(`EVENT_WIDTH)) u_evt (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .set_pulse  (evt_set),
      .clear_ones (evt_clr),
      .flags      (evt_flags)
   );

   sticky_flags #(.WIDTH(NUM_EP)) u_done (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .set_pulse  (ep_done_set),
      .clear_ones (ep_done_clr),
      .flags      (ep_done)
   );

   // the mask does not stop the flag, only the line
   sticky_flags #(.WIDTH(NUM_EP)) u_zlen (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .set_pulse  (ep_zlen_rx),
      .clear_ones (zlen_clr),
      .flags      (zlen)
   );

   // ********************************************************
   // mask register
   // ********************************************************
   always @* begin
      mask_next = mask_reg;
      if (wr_mask)
         mask_next = wr_data_reg[NUM_EP-1:0];
   end

   always @(posedge aclk) begin
      if (!aresetn)
         mask_reg <= `RST_EP;
      else
         mask_reg <= mask_next;
   end

   // ********************************************************
   // per-endpoint gating
   // ********************************************************
   wire [NUM_EP-1:0] ep_gated;
   wire [NUM_EP-1:0] zlen_gated;
   wire              ep_line_next;
   wire              zl_line_next;
   wire              ctrl_pending;
   genvar            g;

   // a set mask bit hides a flag from its line, never from the register
   generate
      for (g = 0; g < NUM_EP; g = g + 1) begin : g_gate
         assign ep_gated[g]   = ep_done[g] & ~mask_reg[g];
         assign zlen_gated[g] = zlen[g] & ~mask_reg[g];
      end
   endgenerate

   // done bit 0 is tied low, so mask bit 0 only ever reaches the zero-length line
   assign ep_line_next = |ep_gated;
   assign zl_line_next = |zlen_gated;
   // control-stage flags have no mask of their own and always reach irq
   assign ctrl_pending = |evt_flags[`BIT_STATUS_DONE:`BIT_SETUP_SEEN];

   // ********************************************************
   // event lines
   // ********************************************************
   // registered so every output of the block comes straight from a flip-flop
   always @(posedge aclk) begin
      if (!aresetn) begin
         endpoint_event_line    <= 1'b0;
         zero_length_event_line <= 1'b0;
         irq                    <= 1'b0;
      end else begin
         endpoint_event_line    <= ep_line_next;
         zero_length_event_line <= zl_line_next;
         irq                    <= ctrl_pending | ep_line_next | zl_line_next;
      end
   end

   // ********************************************************
   // read channel
   // ********************************************************
   reg  [31:0] rd_word;
   wire [31:0] rd_evt_word;
   wire [31:0] rd_done_word;
   wire [31:0] rd_mask_word;
   wire [31:0] rd_zlen_word;
   wire [1:0]  rd_resp;

   // unused upper bits read as zero whatever the endpoint count
   assign rd_evt_word  = {{(32-`EVENT_WIDTH){1'b0}}, evt_flags};
   assign rd_done_word = {{(32-NUM_EP){1'b0}}, ep_done};
   assign rd_mask_word = {{(32-NUM_EP){1'b0}}, mask_reg};
   assign rd_zlen_word = {{(32-NUM_EP){1'b0}}, zlen};
   // only word-aligned reads are legal; an unaligned one returns zero data
   assign rd_resp      = (s_axi_araddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;

   // software must send setup-finish after the status-seen flag; the flag is only reported
   always @* begin
      case (s_axi_araddr)
         `OFS_EVENT_FLAGS: rd_word = rd_evt_word;
         `OFS_EP_DONE:     rd_word = rd_done_word;
         `OFS_EP_MASK:     rd_word = rd_mask_word;
         `OFS_ZLEN_FLAGS:  rd_word = rd_zlen_word;
         default:          rd_word = 32'h0000_0000;
      endcase
   end

   // one read in flight; data and rvalid rise on the same edge as arready, in the cycle the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_resp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // ep_event_flags

//--- verif/usb_host_model.sv
// host-side event source for the endpoint event flag block
`timescale 1ns/1ns
module usb_host_model (
   // clock and request from the bench
   input  wire       aclk,
   input  wire       go,
   input  wire [2:0] kind,
   input  wire [2:0] ep,
   // protocol events toward the block
   output reg        setup_token = 1'b0,
   output reg        status_token = 1'b0,
   output reg        status_token_in = 1'b0,
   output reg        ctrl_read = 1'b0,
   output reg        status_zlp_ok = 1'b0,
   output reg  [7:0] ep_xfer_done = 8'h00,
   output reg  [7:0] ep_zlen_rx = 8'h00
);
   // one-cycle events; qualifiers ride only with their token, never left stale
   always @(posedge aclk) begin
      setup_token <= go && kind == 3'h0;
      status_token <= go && (kind == 3'h1 || kind == 3'h2 || kind == 3'h6);
      ctrl_read <= go && kind == 3'h1;
      status_token_in <= go && kind == 3'h2;
      status_zlp_ok <= go && kind == 3'h3;
      ep_xfer_done <= (go && kind == 3'h4) ? 8'h01 << ep : 8'h00;
      ep_zlen_rx <= (go && kind == 3'h5) ? 8'h01 << ep : 8'h00;
   end
endmodule // usb_host_model

//--- verif/ep_event_flags_asserts.sv
// concurrent checks on the ports of the endpoint event flag block
`timescale 1ns/1ns
module ep_event_asserts #(
   parameter NUM_EP = 8
) (
   // clock and reset
   input wire              aclk,
   input wire              aresetn,
   // register bus handshakes
   input wire              s_axi_awready,
   input wire              s_axi_wready,
   input wire              s_axi_bvalid,
   input wire              s_axi_bready,
   input wire              s_axi_arready,
   input wire              s_axi_rvalid,
   input wire              s_axi_rready,
   // protocol events
   input wire              setup_token,
   input wire              status_token,
   input wire              status_token_in,
   input wire              ctrl_read,
   input wire              status_zlp_ok,
   input wire [NUM_EP-1:0] ep_xfer_done,
   input wire [NUM_EP-1:0] ep_zlen_rx,
   // event lines
   input wire              endpoint_event_line,
   input wire              zero_length_event_line,
   input wire              irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // endpoint 0 is left out: it has no done flag to drive the line
   wire ep_hit = |ep_xfer_done[NUM_EP-1:1];
   wire zl_hit = |ep_zlen_rx;
   sequence write_taken;
      s_axi_awready && s_axi_wready;
   endsequence
   setup_irq_a: assert property (setup_token |-> ##2 irq)
      else $error("setup token did not raise irq");
   status_seen_a: assert property (status_token && (ctrl_read || status_token_in) |-> ##2 irq)
      else $error("status token did not raise irq");
   status_done_a: assert property (status_zlp_ok |-> ##2 irq)
      else $error("status completion did not raise irq");
   ep_line_cause_a: assert property ($rose(endpoint_event_line) |-> $past(ep_hit, 2) || $past(s_axi_wready, 2))
      else $error("endpoint line rose without cause");
   zl_line_cause_a: assert property ($rose(zero_length_event_line) |-> $past(zl_hit, 2) || $past(s_axi_wready, 2))
      else $error("zero-length line rose without cause");
   line_irq_a: assert property (endpoint_event_line || zero_length_event_line |-> irq)
      else $error("event line high without irq");
   write_resp_a: assert property (write_taken |=> s_axi_bvalid)
      else $error("write response late");
   bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   read_resp_a: assert property (s_axi_arready |-> s_axi_rvalid ##1 (!s_axi_rvalid || !$past(s_axi_rready)))
      else $error("read response timing wrong");
endmodule // ep_event_asserts
bind ep_event_flags ep_event_asserts #(.NUM_EP(NUM_EP)) i_chk (.*);

//--- verif/tb_top.sv
// self-checking bench for the endpoint event flag block
`timescale 1ns/1ns
module tb_top;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [3:0]  s_axi_awaddr = 4'h0;
   reg  [3:0]  s_axi_araddr = 4'h0;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hF;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   reg         s_axi_bready = 1'b1, s_axi_rready = 1'b1, go = 1'b0;
   reg  [2:0]  kind = 3'h0, ep = 3'h0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        setup_token, status_token, status_token_in, ctrl_read, status_zlp_ok;
   wire [7:0]  ep_xfer_done, ep_zlen_rx;
   wire        endpoint_event_line, zero_length_event_line, irq;
   integer     err_total = 0, comparisons = 0, i, n;
   ep_event_flags #(.NUM_EP(8)) i_dut (.*);
   usb_host_model i_host (.*);
   always #25 aclk = ~aclk;
   // ***************************
   // shared tasks
   // ***************************
   task print_verdict;
      begin
         if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // bready and rready stay high, so each wait ends at the answer edge
   task wr(input [3:0] a, input [7:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         for (n = 0; n < 40 && n >= 0; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               chk("bresp", s_axi_bresp, 32'h0);
               n = -9;
            end
         end
         if (n >= 0) begin err_total = err_total + 1; print_verdict; end
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         for (n = 0; n < 40 && n >= 0; n = n + 1) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
               chk("rdata", s_axi_rdata, {24'h0, e});
               chk("rresp", s_axi_rresp, (a[1:0] == 2'h0) ? 32'h0 : 32'h2);
               n = -9;
            end
         end
         // let one edge pass so a following read never re-raises arvalid in this step
         @(posedge aclk);
         if (n >= 0) begin err_total = err_total + 1; print_verdict; end
      end
   endtask
   // lines lag the flags by one cycle, hence the extra edge
   task lines(input [2:0] e);
      begin
         @(posedge aclk);
         chk("lines", {29'h0, irq, endpoint_event_line, zero_length_event_line}, {29'h0, e});
      end
   endtask
   task ev(input [2:0] k, input [2:0] e);
      begin
         go <= 1'b1;
         kind <= k;
         ep <= e;
         @(posedge aclk);
         go <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
   // ***************************
   // scenarios
   // ***************************
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(4'h4, 8'h00);
      rd(4'h8, 8'h00);
      lines(3'h0);
      ev(3'h0, 3'h0);
      rd(4'h0, 8'h01);
      lines(3'h4);
      wr(4'h0, 8'h01);
      ev(3'h6, 3'h0);
      rd(4'h0, 8'h00);
      ev(3'h1, 3'h0);
      rd(4'h0, 8'h02);
      wr(4'h0, 8'h02);
      ev(3'h2, 3'h0);
      rd(4'h0, 8'h02);
      wr(4'h0, 8'h02);
      ev(3'h3, 3'h0);
      rd(4'h0, 8'h04);
      wr(4'h0, 8'h04);
      lines(3'h0);
      for (i = 0; i < 8; i = i + 1) ev(3'h4, i[2:0]);
      rd(4'h4, 8'hFE);
      lines(3'h6);
      wr(4'h8, 8'hFE);
      lines(3'h0);
      rd(4'h4, 8'hFE);
      wr(4'h8, 8'h01);
      lines(3'h6);
      wr(4'h4, 8'h00);
      rd(4'h4, 8'hFE);
      wr(4'h4, 8'h04);
      rd(4'h4, 8'hFA);
      wr(4'h0, 8'h40);
      rd(4'h4, 8'h00);
      wr(4'h8, 8'hFF);
      for (i = 0; i < 8; i = i + 1) ev(3'h5, i[2:0]);
      rd(4'hC, 8'hFF);
      lines(3'h0);
      wr(4'h8, 8'h01);
      lines(3'h5);
      wr(4'hC, 8'hFE);
      lines(3'h0);
      wr(4'h8, 8'h00);
      lines(3'h5);
      wr(4'h0, 8'h08);
      lines(3'h0);
      rd(4'h2, 8'h00);
      print_verdict;
   end
endmodule // tb_top
